// ==== css_consts.svh ====
`ifndef CSS_CONSTS_SVH
`define CSS_CONSTS_SVH
// language codes
`define CSS_LANG_DEFAULT    4'h0
`define CSS_LANG_MAX_LOW    4'h9
`define CSS_LANG_POLISH     4'hB
// motor set
`define CSS_MOTOR_DEFAULT   2'h0
// control mode
`define CSS_MODE_FREQ       2'h2
`define CSS_MODE_DEFAULT    2'h2
// reference / run sources
`define CSS_SRC_TERM        2'h0
`define CSS_SRC_PANEL       2'h1
`define CSS_SRC_COMM        2'h2
`define CSS_SRC_OPTION      2'h3
`define CSS_REF_DEFAULT     2'h0
`define CSS_RUN_DEFAULT     2'h0
// reset sources
`define CSS_RST_TERM        3'h0
`define CSS_RST_PANEL       3'h1
`define CSS_RST_COMM        3'h2
`define CSS_RST_TERM_PANEL  3'h3
`define CSS_RST_COMM_PANEL  3'h4
`define CSS_RST_ALL         3'h5
`define CSS_RST_OPTION      3'h6
`define CSS_RST_DEFAULT     3'h3
// reference word
`define CSS_REF_ZERO        16'h0000
`endif

// ==== css_pkg.sv ====
package css_pkg;
   typedef enum logic [1:0] {
      CSS_SEL_TERM   = 2'h0,
      CSS_SEL_PANEL  = 2'h1,
      CSS_SEL_COMM   = 2'h2,
      CSS_SEL_OPTION = 2'h3
   } css_src_t;
   typedef enum logic [2:0] {
      CSS_FS_IDLE    = 3'b001,
      CSS_FS_FAULTED = 3'b010,
      CSS_FS_CLEARED = 3'b100
   } css_fault_t;
endpackage

// ==== css_fault_latch.sv ====
`timescale 1ns/100ps
`include "css_consts.svh"
// holds the drive in fault until a reset from a permitted source arrives
module css_fault_latch (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // fault handling
   input  wire logic fault_in,
   input  wire logic reset_accepted,
   output logic      fault_hold
);
   css_pkg::css_fault_t state_reg;
   css_pkg::css_fault_t state_next;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         css_pkg::CSS_FS_IDLE: begin
            if (fault_in) begin
               state_next = css_pkg::CSS_FS_FAULTED;
            end
         end
         css_pkg::CSS_FS_FAULTED: begin
            if (reset_accepted && !fault_in) begin
               state_next = css_pkg::CSS_FS_CLEARED;
            end
         end
         css_pkg::CSS_FS_CLEARED: begin
            state_next = fault_in ? css_pkg::CSS_FS_FAULTED : css_pkg::CSS_FS_IDLE;
         end
         default: begin
            state_next = css_pkg::CSS_FS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg <= css_pkg::CSS_FS_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   assign fault_hold = (state_reg == css_pkg::CSS_FS_FAULTED);
endmodule // css_fault_latch

// ==== css_selector.sv ====
// Overview of operation
// - load-defaults keeps the stored display language unchanged.
// - language accepts codes 0..9 and 11, default 0; 10 rejected.
// - four motor data sets selected by two-bit code, set 0 after reset.
// - motor data writes go only to the currently selected motor set.
// - control mode supports only frequency mode, code 2, also default.
// - speed values keep rpm units but magnitudes mean output frequency.
// - reference source codes: 0 terminal, 1 panel, 2 comm, 3 option.
// - panel plus/minus change reference only in set/view-reference menu.
// - option reference code accepted only if option can drive reference.
// - switching terminal to panel loads panel reference with last terminal value.
// - drive stops when selected reference or run source is lost.
// - run/stop source codes: 0 terminal, 1 panel, 2 comm, 3 option.
// - after fault stop, restart refused until reset from permitted source.
// - reset source codes 0..6, default 3 terminal or panel.
// - combined reset codes accept reset from any enabled source.
// - option reset code accepted only if option can issue reset.
// - run-locked settings reject writes while the drive is running.
`timescale 1ns/100ps
`include "css_consts.svh"
module css_selector #(
   parameter int REF_W = 16,
   parameter int MOT_W = 16
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // setting writes
   input  wire logic             load_defaults,
   input  wire logic             lang_wr,
   input  wire logic [3:0]       lang_wdata,
   input  wire logic             motor_sel_wr,
   input  wire logic [1:0]       motor_sel_wdata,
   input  wire logic             mode_wr,
   input  wire logic [1:0]       mode_wdata,
   input  wire logic             ref_src_wr,
   input  wire logic [1:0]       ref_src_wdata,
   input  wire logic             run_src_wr,
   input  wire logic [1:0]       run_src_wdata,
   input  wire logic             rst_src_wr,
   input  wire logic [2:0]       rst_src_wdata,
   // motor data write
   input  wire logic             motor_data_wr,
   input  wire logic [MOT_W-1:0] motor_data_wdata,
   // option capabilities (asynchronous)
   input  wire logic             opt_ref_capable,
   input  wire logic             opt_rst_capable,
   // reference sources
   input  wire logic [REF_W-1:0] term_ref,
   input  wire logic [REF_W-1:0] comm_ref,
   input  wire logic [REF_W-1:0] opt_ref,
   input  wire logic             key_plus,
   input  wire logic             key_minus,
   input  wire logic             menu_ref_active,
   // run sources (asynchronous pins)
   input  wire logic             term_run,
   input  wire logic             panel_run,
   input  wire logic             comm_run,
   input  wire logic             opt_run,
   // reset sources (asynchronous pins)
   input  wire logic             term_reset,
   input  wire logic             panel_reset,
   input  wire logic             comm_reset,
   input  wire logic             opt_reset,
   // drive core status
   input  wire logic             drive_running,
   input  wire logic             fault_in,
   input  wire logic             src_lost,
   // settings read back
   output logic [3:0]            lang_out,
   output logic [1:0]            motor_sel_out,
   output logic [1:0]            mode_out,
   output logic [1:0]            ref_src_out,
   output logic [1:0]            run_src_out,
   output logic [2:0]            rst_src_out,
   // to drive core
   output logic [REF_W-1:0]      ref_out,
   output logic                  speed_is_freq,
   output logic                  run_out,
   output logic                  fault_reset_out,
   output logic                  fault_active,
   output logic [MOT_W-1:0]      motor_data_first,
   output logic [MOT_W-1:0]      motor_data_second,
   output logic [MOT_W-1:0]      motor_data_third,
   output logic [MOT_W-1:0]      motor_data_fourth
);
   // two-stage synchronisers for pin-side levels
   logic [9:0] sync1_reg;
   logic [9:0] sync2_reg;
   logic [9:0] pins;
   assign pins = {opt_ref_capable, opt_rst_capable, term_run, panel_run, comm_run, opt_run,
                  term_reset, panel_reset, comm_reset, opt_reset};
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sync1_reg <= 10'h000;
         sync2_reg <= 10'h000;
      end else begin
         sync1_reg <= pins;
         sync2_reg <= sync1_reg;
      end
   end
   logic s_opt_ref_cap, s_opt_rst_cap, s_term_run, s_panel_run, s_comm_run, s_opt_run;
   logic s_term_rst, s_panel_rst, s_comm_rst, s_opt_rst;
   assign {s_opt_ref_cap, s_opt_rst_cap, s_term_run, s_panel_run, s_comm_run, s_opt_run,
           s_term_rst, s_panel_rst, s_comm_rst, s_opt_rst} = sync2_reg;

   // settings
   logic [3:0]       lang_reg, lang_next;
   logic [1:0]       motor_sel_reg, motor_sel_next;
   logic [1:0]       mode_reg, mode_next;
   logic [1:0]       ref_src_reg, ref_src_next;
   logic [1:0]       run_src_reg, run_src_next;
   logic [2:0]       rst_src_reg, rst_src_next;
   logic [REF_W-1:0] panel_ref_reg, panel_ref_next;
   logic [REF_W-1:0] last_term_reg, last_term_next;
   logic [MOT_W-1:0] motor_data_reg [4];
   logic [MOT_W-1:0] motor_data_next [4];
   logic             locked;

   function automatic logic lang_ok(input logic [3:0] code);
      lang_ok = (code <= `CSS_LANG_MAX_LOW) || (code == `CSS_LANG_POLISH);
   endfunction

   // an option-board code is only taken once the board reports the matching capability
   function automatic logic opt_gate(input logic is_opt, input logic capable);
      opt_gate = !is_opt || capable;
   endfunction

   // run-locked settings drop their writes while the drive runs
   assign locked = drive_running;

   always_comb begin
      lang_next       = lang_reg;
      motor_sel_next  = motor_sel_reg;
      mode_next       = mode_reg;
      ref_src_next    = ref_src_reg;
      run_src_next    = run_src_reg;
      rst_src_next    = rst_src_reg;
      panel_ref_next  = panel_ref_reg;
      last_term_next  = last_term_reg;
      for (int i = 0; i < 4; i++) begin
         motor_data_next[i] = motor_data_reg[i];
      end
      // the copy of the terminal reference follows it while the terminal is the source
      if (ref_src_reg == `CSS_SRC_TERM) begin
         last_term_next = term_ref;
      end
      if (load_defaults && !locked) begin
         // language deliberately left alone
         motor_sel_next = `CSS_MOTOR_DEFAULT;
         mode_next      = `CSS_MODE_DEFAULT;
         ref_src_next   = `CSS_REF_DEFAULT;
         run_src_next   = `CSS_RUN_DEFAULT;
         rst_src_next   = `CSS_RST_DEFAULT;
      end else begin
         if (lang_wr && lang_ok(lang_wdata)) begin
            lang_next = lang_wdata;
         end
         if (motor_sel_wr) begin
            motor_sel_next = motor_sel_wdata;
         end
         if (mode_wr && !locked && mode_wdata == `CSS_MODE_FREQ) begin
            mode_next = mode_wdata;
         end
         if (ref_src_wr && opt_gate(ref_src_wdata == `CSS_SRC_OPTION, s_opt_ref_cap)) begin
            ref_src_next = ref_src_wdata;
            if (ref_src_reg == `CSS_SRC_TERM && ref_src_wdata == `CSS_SRC_PANEL) begin
               panel_ref_next = last_term_reg;
            end
         end
         if (run_src_wr && !locked) begin
            run_src_next = run_src_wdata;
         end
         if (rst_src_wr && rst_src_wdata <= `CSS_RST_OPTION
             && opt_gate(rst_src_wdata == `CSS_RST_OPTION, s_opt_rst_cap)) begin
            rst_src_next = rst_src_wdata;
         end
      end
      if (motor_data_wr && !locked) begin
         motor_data_next[motor_sel_reg] = motor_data_wdata;
      end
      // held keys step the panel reference once per clock, stopping at either end
      if (ref_src_reg == `CSS_SRC_PANEL && menu_ref_active) begin
         if (key_plus && !key_minus && panel_ref_reg != {REF_W{1'b1}}) begin
            panel_ref_next = panel_ref_reg + REF_W'(1);
         end else if (key_minus && !key_plus && panel_ref_reg != '0) begin
            panel_ref_next = panel_ref_reg - REF_W'(1);
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lang_reg      <= `CSS_LANG_DEFAULT;
         motor_sel_reg <= `CSS_MOTOR_DEFAULT;
         mode_reg      <= `CSS_MODE_DEFAULT;
         ref_src_reg   <= `CSS_REF_DEFAULT;
         run_src_reg   <= `CSS_RUN_DEFAULT;
         rst_src_reg   <= `CSS_RST_DEFAULT;
         panel_ref_reg <= '0;
         last_term_reg <= '0;
         for (int i = 0; i < 4; i++) begin
            motor_data_reg[i] <= '0;
         end
      end else begin
         lang_reg      <= lang_next;
         motor_sel_reg <= motor_sel_next;
         mode_reg      <= mode_next;
         ref_src_reg   <= ref_src_next;
         run_src_reg   <= run_src_next;
         rst_src_reg   <= rst_src_next;
         panel_ref_reg <= panel_ref_next;
         last_term_reg <= last_term_next;
         for (int i = 0; i < 4; i++) begin
            motor_data_reg[i] <= motor_data_next[i];
         end
      end
   end

   // reset source decode
   logic reset_accepted;
   always_comb begin
      case (rst_src_reg)
         `CSS_RST_TERM:       reset_accepted = s_term_rst;
         `CSS_RST_PANEL:      reset_accepted = s_panel_rst;
         `CSS_RST_COMM:       reset_accepted = s_comm_rst;
         `CSS_RST_TERM_PANEL: reset_accepted = s_term_rst | s_panel_rst;
         `CSS_RST_COMM_PANEL: reset_accepted = s_comm_rst | s_panel_rst;
         `CSS_RST_ALL:        reset_accepted = s_term_rst | s_panel_rst | s_comm_rst;
         `CSS_RST_OPTION:     reset_accepted = s_opt_rst & s_opt_rst_cap;
         default:             reset_accepted = 1'b0;
      endcase
   end

   // a stop on fault is held until an accepted reset
   logic fault_hold;
   css_fault_latch u_fault (
      .clk            (clk),
      .rst            (rst),
      .fault_in       (fault_in),
      .reset_accepted (reset_accepted),
      .fault_hold     (fault_hold)
   );

   // registered source multiplexers
   logic [REF_W-1:0] ref_mux;
   logic             run_mux;
   logic [REF_W-1:0] ref_out_next;
   logic             run_out_next;
   logic             fault_reset_next;
   logic             fault_active_next;
   logic             speed_is_freq_next;
   always_comb begin
      case (ref_src_reg)
         `CSS_SRC_TERM:   ref_mux = term_ref;
         `CSS_SRC_PANEL:  ref_mux = panel_ref_reg;
         `CSS_SRC_COMM:   ref_mux = comm_ref;
         `CSS_SRC_OPTION: ref_mux = opt_ref;
         default:         ref_mux = term_ref;
      endcase
      case (run_src_reg)
         `CSS_SRC_TERM:   run_mux = s_term_run;
         `CSS_SRC_PANEL:  run_mux = s_panel_run;
         `CSS_SRC_COMM:   run_mux = s_comm_run;
         `CSS_SRC_OPTION: run_mux = s_opt_run;
         default:         run_mux = 1'b0;
      endcase
      ref_out_next       = ref_mux;
      // a lost source or a held fault forces the run command low
      run_out_next       = run_mux & ~fault_hold & ~src_lost;
      fault_reset_next   = reset_accepted;
      fault_active_next  = fault_hold;
      speed_is_freq_next = (mode_reg == `CSS_MODE_FREQ);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ref_out         <= '0;
         run_out         <= 1'b0;
         fault_reset_out <= 1'b0;
         fault_active    <= 1'b0;
         speed_is_freq   <= 1'b1;
      end else begin
         ref_out         <= ref_out_next;
         run_out         <= run_out_next;
         fault_reset_out <= fault_reset_next;
         fault_active    <= fault_active_next;
         speed_is_freq   <= speed_is_freq_next;
      end
   end

   assign lang_out          = lang_reg;
   assign motor_sel_out     = motor_sel_reg;
   assign mode_out          = mode_reg;
   assign ref_src_out       = ref_src_reg;
   assign run_src_out       = run_src_reg;
   assign rst_src_out       = rst_src_reg;
   assign motor_data_first  = motor_data_reg[0];
   assign motor_data_second = motor_data_reg[1];
   assign motor_data_third  = motor_data_reg[2];
   assign motor_data_fourth = motor_data_reg[3];
endmodule // css_selector

// ==== css_selector_checker.sv ====
`timescale 1ns/100ps
`include "css_consts.svh"
module css_selector_checker #(
   parameter int REF_W = 16
) (
   // clock and reset
   input wire logic             clk,
   input wire logic             rst,
   // setting writes and option capabilities
   input wire logic             load_defaults,
   input wire logic             lang_wr,
   input wire logic             ref_src_wr,
   input wire logic             run_src_wr,
   input wire logic             rst_src_wr,
   input wire logic [3:0]       lang_wdata,
   input wire logic [1:0]       ref_src_wdata,
   input wire logic [2:0]       rst_src_wdata,
   input wire logic             opt_ref_capable,
   input wire logic             opt_rst_capable,
   input wire logic             menu_ref_active,
   // drive core status
   input wire logic             drive_running,
   input wire logic             fault_in,
   input wire logic             src_lost,
   // outputs watched
   input wire logic [3:0]       lang_out,
   input wire logic [1:0]       mode_out,
   input wire logic [1:0]       ref_src_out,
   input wire logic [1:0]       run_src_out,
   input wire logic [2:0]       rst_src_out,
   input wire logic [REF_W-1:0] ref_out,
   input wire logic             speed_is_freq,
   input wire logic             run_out,
   input wire logic             fault_active
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_panel_quiet;
      ref_src_out == `CSS_SRC_PANEL && !menu_ref_active && !ref_src_wr && !load_defaults;
   endsequence
   sequence s_opt_ref_write;
      !opt_ref_capable[*3] ##0 (ref_src_wr && ref_src_wdata == 2'h3 && !load_defaults);
   endsequence
   sequence s_opt_rst_write;
      !opt_rst_capable[*3] ##0 (rst_src_wr && rst_src_wdata == 3'h6 && !load_defaults);
   endsequence

   AST_LANG_TEN: assert property (lang_wr && lang_wdata == 4'hA && !load_defaults |=> $stable(lang_out))
      else $error("language code ten was taken");
   AST_LANG_KEEP: assert property (load_defaults && !lang_wr |=> $stable(lang_out))
      else $error("language changed by load defaults");
   AST_MODE_FREQ: assert property (mode_out == `CSS_MODE_FREQ && speed_is_freq)
      else $error("control mode left frequency mode");
   AST_REF_OPT: assert property (s_opt_ref_write |=> $stable(ref_src_out))
      else $error("option reference taken without capability");
   AST_RST_OPT: assert property (s_opt_rst_write |=> $stable(rst_src_out))
      else $error("option reset source taken without capability");
   AST_RUN_LOCK: assert property (drive_running && run_src_wr |=> $stable(run_src_out))
      else $error("run source changed while running");
   AST_PANEL_HOLD: assert property (s_panel_quiet[*3] |=> $stable(ref_out))
      else $error("panel reference moved outside its menu");
   AST_FAULT: assert property ($rose(fault_in) |-> ##2 fault_active)
      else $error("fault not latched in two cycles");
   AST_FAULT_RUN: assert property (fault_active && $past(fault_active) |-> !run_out)
      else $error("run while faulted");
   AST_LOST: assert property (src_lost |=> !run_out)
      else $error("run kept after source loss");
endmodule // css_selector_checker

bind css_selector css_selector_checker #(.REF_W(REF_W)) u_chk (
   .clk(clk), .rst(rst), .load_defaults(load_defaults), .lang_wr(lang_wr), .ref_src_wr(ref_src_wr),
   .run_src_wr(run_src_wr), .rst_src_wr(rst_src_wr), .lang_wdata(lang_wdata), .ref_src_wdata(ref_src_wdata),
   .rst_src_wdata(rst_src_wdata), .opt_ref_capable(opt_ref_capable), .opt_rst_capable(opt_rst_capable),
   .menu_ref_active(menu_ref_active), .drive_running(drive_running), .fault_in(fault_in), .src_lost(src_lost),
   .lang_out(lang_out), .mode_out(mode_out), .ref_src_out(ref_src_out), .run_src_out(run_src_out),
   .rst_src_out(rst_src_out), .ref_out(ref_out), .speed_is_freq(speed_is_freq), .run_out(run_out),
   .fault_active(fault_active));

// ==== css_field_model.sv ====
`timescale 1ns/100ps
// terminal strip, panel, link and option board: only the chosen party raises its line
module css_field_model (
   // requests from the bench
   input wire logic [1:0] run_sel,
   input wire logic       run_on,
   input wire logic [1:0] rst_sel,
   input wire logic       rst_on,
   // run pins
   output logic           term_run,
   output logic           panel_run,
   output logic           comm_run,
   output logic           opt_run,
   // reset pins
   output logic           term_reset,
   output logic           panel_reset,
   output logic           comm_reset,
   output logic           opt_reset
);
   always_comb begin
      {opt_run, comm_run, panel_run, term_run} = run_on ? (4'h1 << run_sel) : 4'h0;
      {opt_reset, comm_reset, panel_reset, term_reset} = rst_on ? (4'h1 << rst_sel) : 4'h0;
   end
endmodule // css_field_model

// ==== css_selector_tb_top.sv ====
`timescale 1ns/100ps
`include "css_consts.svh"
module css_selector_tb_top;
   logic clk = 1'b0, rst = 1'b1;
   logic load_defaults, lang_wr, motor_sel_wr, mode_wr, ref_src_wr, run_src_wr, rst_src_wr, motor_data_wr;
   logic opt_ref_capable, opt_rst_capable, key_plus, key_minus, menu_ref_active, drive_running, fault_in, src_lost;
   logic [3:0] lang_wdata, lang_out;
   logic [1:0] motor_sel_wdata, mode_wdata, ref_src_wdata, run_src_wdata, run_sel, rst_sel;
   logic [1:0] motor_sel_out, mode_out, ref_src_out, run_src_out;
   logic [2:0] rst_src_wdata, rst_src_out;
   logic [15:0] motor_data_wdata, term_ref, comm_ref, opt_ref, ref_out;
   logic [15:0] motor_data_first, motor_data_second, motor_data_third, motor_data_fourth;
   logic speed_is_freq, run_out, fault_reset_out, fault_active, run_on, rst_on;
   logic term_run, panel_run, comm_run, opt_run, term_reset, panel_reset, comm_reset, opt_reset;
   int n_mismatch = 0, n_checks = 0;
   int tbl [16][3] = '{'{0,0,1}, '{0,1,0}, '{1,1,1}, '{1,0,0}, '{2,2,1}, '{2,1,0}, '{3,0,1}, '{3,1,1},
                       '{3,2,0}, '{4,2,1}, '{4,1,1}, '{4,0,0}, '{5,0,1}, '{5,1,1}, '{5,2,1}, '{5,3,0}};

   css_selector uut (.*);
   css_field_model u_field (.*);

   initial forever #12.5 clk = ~clk;

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask
   task automatic wrap_up();
      if (n_mismatch == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   // f selects fault_active, otherwise run_out
   task automatic wt(input bit f, input logic e);
      int i;
      for (i = 0; i < 12 && (f ? fault_active : run_out) !== e; i++) cyc(1);
      if (i == 12) begin
         n_mismatch++;
         wrap_up();
      end
   endtask
   task automatic wr(input int k, input logic [15:0] v);
      case (k)
         0: begin lang_wr = 1'b1; lang_wdata = v[3:0]; end
         1: begin motor_sel_wr = 1'b1; motor_sel_wdata = v[1:0]; end
         2: begin mode_wr = 1'b1; mode_wdata = v[1:0]; end
         3: begin ref_src_wr = 1'b1; ref_src_wdata = v[1:0]; end
         4: begin run_src_wr = 1'b1; run_src_wdata = v[1:0]; end
         5: begin rst_src_wr = 1'b1; rst_src_wdata = v[2:0]; end
         6: begin motor_data_wr = 1'b1; motor_data_wdata = v; end
         default: load_defaults = 1'b1;
      endcase
      cyc(1);
      {lang_wr, motor_sel_wr, mode_wr, ref_src_wr, run_src_wr, rst_src_wr, motor_data_wr, load_defaults} = '0;
      cyc(1);
   endtask

   task automatic t_lang();
      chk(rst_src_out, `CSS_RST_DEFAULT);
      chk(run_src_out, `CSS_RUN_DEFAULT);
      chk(ref_out, `CSS_REF_ZERO);
      for (int i = 0; i < 12; i++) begin
         wr(0, 16'(i));
         chk(lang_out, (i == 10) ? 9 : i);
      end
      wr(3, 16'h0002);
      wr(7, 16'h0000);
      chk(lang_out, `CSS_LANG_POLISH);
      chk(ref_src_out, `CSS_REF_DEFAULT);
   endtask
   task automatic t_motor();
      chk(motor_sel_out, `CSS_MOTOR_DEFAULT);
      for (int i = 0; i < 4; i++) begin
         wr(1, 16'(i));
         chk(motor_sel_out, i);
         wr(6, 16'h1000 + 16'(i));
      end
      chk({motor_data_first, motor_data_second}, 32'h1000_1001);
      chk({motor_data_third, motor_data_fourth}, 32'h1002_1003);
      wr(2, 16'h0001);
      chk(mode_out, `CSS_MODE_DEFAULT);
      chk(speed_is_freq, 1'b1);
      drive_running = 1'b1;
      wr(6, 16'hBEEF);
      wr(4, 16'h0001);
      chk(motor_data_fourth, 16'h1003);
      chk(run_src_out, `CSS_RUN_DEFAULT);
      drive_running = 1'b0;
   endtask
   task automatic t_ref();
      term_ref = 16'h1234;
      comm_ref = 16'h2222;
      opt_ref = 16'h3333;
      cyc(2);
      chk(ref_out, 16'h1234);
      wr(3, 16'h0001);
      term_ref = 16'h0000;
      chk(ref_out, 16'h1234);
      key_plus = 1'b1;
      cyc(3);
      chk(ref_out, 16'h1234);
      menu_ref_active = 1'b1;
      cyc(1);
      key_plus = 1'b0;
      menu_ref_active = 1'b0;
      cyc(2);
      chk(ref_out, 16'h1235);
      key_minus = 1'b1;
      menu_ref_active = 1'b1;
      cyc(1);
      key_minus = 1'b0;
      menu_ref_active = 1'b0;
      cyc(2);
      chk(ref_out, 16'h1234);
      wr(3, 16'h0002);
      chk(ref_out, 16'h2222);
      wr(3, 16'h0003);
      chk(ref_src_out, `CSS_SRC_COMM);
      opt_ref_capable = 1'b1;
      cyc(3);
      wr(3, 16'h0003);
      cyc(1);
      chk(ref_out, 16'h3333);
   endtask
   task automatic t_run();
      for (int i = 0; i < 4; i++) begin
         wr(4, 16'(i));
         run_sel = 2'(i);
         run_on = 1'b1;
         wt(0, 1'b1);
         chk(run_out, 1'b1);
         run_sel = 2'(i + 1);
         cyc(6);
         chk(run_out, 1'b0);
      end
      wr(4, 16'h0000);
      run_sel = 2'h0;
      wt(0, 1'b1);
      src_lost = 1'b1;
      cyc(1);
      chk(run_out, 1'b0);
      src_lost = 1'b0;
   endtask
   task automatic fr(input int c, input int s, input int ok);
      fault_in = 1'b1;
      cyc(1);
      fault_in = 1'b0;
      wt(1, 1'b1);
      chk(run_out, 1'b0);
      wr(5, 16'(c));
      rst_sel = 2'(s);
      rst_on = 1'b1;
      cyc(6);
      chk(fault_reset_out, ok != 0);
      rst_on = 1'b0;
      chk(fault_active, ok == 0);
      wr(5, 16'h0005);
      rst_sel = 2'h0;
      rst_on = 1'b1;
      cyc(1);
      wt(1, 1'b0);
      rst_on = 1'b0;
      cyc(4);
   endtask
   task automatic t_rst();
      foreach (tbl[i]) fr(tbl[i][0], tbl[i][1], tbl[i][2]);
      wr(5, 16'h0006);
      chk(rst_src_out, `CSS_RST_ALL);
      opt_rst_capable = 1'b1;
      cyc(3);
      fr(6, 3, 1);
      fr(6, 0, 0);
   endtask

   initial begin
      {load_defaults, lang_wr, motor_sel_wr, mode_wr, ref_src_wr, run_src_wr, rst_src_wr, motor_data_wr} = '0;
      {opt_ref_capable, opt_rst_capable, key_plus, key_minus, menu_ref_active, drive_running} = '0;
      {fault_in, src_lost, run_on, rst_on, run_sel, rst_sel, lang_wdata, motor_sel_wdata, mode_wdata} = '0;
      {ref_src_wdata, run_src_wdata, rst_src_wdata, motor_data_wdata, term_ref, comm_ref, opt_ref} = '0;
      repeat (12) @(posedge clk);
      #2 rst = 1'b0;
      cyc(1);
      t_lang();
      t_motor();
      t_ref();
      t_run();
      t_rst();
      wrap_up();
   end
endmodule // css_selector_tb_top
